// ==== common/flash_cmd_pkg.sv ====
// Constants shared by the serial flash command front end.
// Assumes a 50 MHz system clock and a mode 0/3 single-wire link clock.
package flash_cmd_pkg;
    localparam logic [7:0] OP_WRITE_ENABLE    = 8'h06;
    localparam logic [7:0] OP_VOLATILE_WE     = 8'h50;
    localparam logic [7:0] OP_WRITE_DISABLE   = 8'h04;
    localparam logic [7:0] OP_READ_STATUS1    = 8'h05;
    localparam logic [7:0] OP_READ_STATUS2    = 8'h35;
    localparam logic [7:0] OP_WRITE_STATUS    = 8'h01;
    localparam logic [7:0] OP_WRITE_STATUS2   = 8'h31;
    localparam logic [7:0] OP_READ_DATA       = 8'h03;
    localparam logic [7:0] OP_FAST_READ       = 8'h0B;
    localparam logic [7:0] OP_SET_READ_PARAM  = 8'hC0;
    localparam logic [7:0] OP_RESET_ENABLE    = 8'h66;
    localparam logic [7:0] OP_RESET           = 8'h99;
    localparam logic [7:0] OP_PAGE_PROGRAM    = 8'h02;
    localparam logic [7:0] OP_QUAD_PROGRAM    = 8'h33;
    localparam logic [7:0] OP_ERASE_4K        = 8'h20;
    localparam logic [7:0] OP_ERASE_32K       = 8'h52;
    localparam logic [7:0] OP_ERASE_64K       = 8'hD8;
    localparam logic [7:0] OP_CHIP_ERASE_A    = 8'h60;
    localparam logic [7:0] OP_CHIP_ERASE_B    = 8'hC7;

    // Bit positions inside status register one and two and the read parameter.
    localparam int SR1_BUSY       = 0;
    localparam int SR1_WEL        = 1;
    localparam int SR1_PROTECT0   = 7;
    localparam int SR2_PROTECT1   = 0;
    localparam int SR2_QUAD       = 1;
    localparam int SR2_COMPLEMENT = 6;
    localparam int PARAM_DUMMY_LO = 4;
    localparam int PARAM_DUMMY_HI = 5;

    // Edge indices and frame lengths counted in link clock rising edges.
    localparam logic [5:0] OPCODE_LAST    = 6'h07;
    localparam logic [5:0] ADDR_LAST      = 6'h1F;
    localparam logic [5:0] FRAME_BITS_MAX = 6'h3F;
    localparam logic [5:0] FRAME_ONE_BYTE = 6'h08;
    localparam logic [5:0] FRAME_TWO_BYTE = 6'h10;
    localparam logic [5:0] FRAME_THREE    = 6'h18;
    localparam logic [2:0] BIT_LAST       = 3'h7;

    localparam logic [5:0] DUMMY_SPI      = 6'h08;
    localparam logic [5:0] DUMMY_QUAD_4   = 6'h04;
    localparam logic [5:0] DUMMY_QUAD_6   = 6'h06;
    localparam logic [5:0] DUMMY_QUAD_8   = 6'h08;
    localparam logic [1:0] DUMMY_SEL_4    = 2'h0;
    localparam logic [1:0] DUMMY_SEL_6    = 2'h1;

    localparam logic [7:0] READ_PARAM_RESET = 8'h00;
    localparam logic       PROTECT0_RESET   = 1'h0;
    localparam logic       PROTECT1_RESET   = 1'h0;
    localparam logic       QUAD_RESET       = 1'h1;
    localparam logic       COMPLEMENT_RESET = 1'h0;

    localparam int CLK_FREQ_MHZ         = 50;
    localparam int STATUS_WRITE_TIME_US = 1000;
    localparam int STATUS_WRITE_CYCLES  = STATUS_WRITE_TIME_US * CLK_FREQ_MHZ;
endpackage : flash_cmd_pkg

// ==== rtl/flash_cmd_front.sv ====
// Command front end of a serial flash: write enable latch, status registers, array reads.
// Assumes the host frames every command with csN and drives sck only inside a frame;
// the array is a read port on the link clock, program and erase engines sit outside.
`timescale 1ns/1ns
module flash_cmd_front #(
    parameter int STATUS_WRITE_CYCLES = flash_cmd_pkg::STATUS_WRITE_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        sck,
    input  wire logic        csN,
    input  wire logic        si,
    output logic             so,
    output logic             soEn,
    output logic [23:0]      arrayAddr,
    input  wire logic [7:0]  arrayData,
    input  wire logic        quadCommandMode,
    input  wire logic        progEraseBusy,
    input  wire logic        progEraseDone,
    output logic             progEraseReq,
    output logic [7:0]       progEraseOpcode,
    output logic             writeEnableLatch,
    output logic             statusWriteBusy,
    output logic             protectBitZero,
    output logic             protectBitOne,
    output logic             quadEnableBit,
    output logic             protectComplementBit,
    output logic [7:0]       readParam
);
    typedef struct packed {
        logic [5:0]  cnt;
        logic [23:0] shiftIn;
        logic [7:0]  opcode;
        logic        dataActive;
        logic        isStatus;
        logic [2:0]  bitIdx;
        logic [23:0] addr;
    } link_state_t;

    typedef struct packed {
        logic        csMeta;
        logic        csSync;
        logic        csPrev;
        logic        freshMeta;
        logic        freshSync;
        logic        ran;
        logic        write_enable_latch;
        logic        volArmed;
        logic        resetArmed;
        logic        protect_bit_zero;
        logic        qe;
        logic        protect_bit_one;
        logic        cmp;
        logic        nvSrp0;
        logic        nvQe;
        logic        nvSrp1;
        logic        nvCmp;
        logic        swBusy;
        logic [31:0] timer;
        logic [3:0]  pend;
        logic [7:0]  readParam;
        logic [7:0]  viewSr1;
        logic [7:0]  viewSr2;
        logic [5:0]  viewDummy;
        logic        viewBusy;
        logic        peReq;
        logic [7:0]  peOpcode;
    } ctrl_state_t;

    link_state_t lk;
    link_state_t next_lk;
    ctrl_state_t st;
    ctrl_state_t next_st;
    logic        fresh;
    logic [5:0]  edgeIdx;
    logic [23:0] shifted;
    logic [7:0]  outByte;
    logic        frameEnd;
    logic        busyNow;
    logic        isPeOp;
    logic        wsValid;
    logic [3:0]  wsNew;

    // Link domain: a frame starts fresh whenever chip select has been high.
    always_ff @(posedge sck or posedge csN) begin
        if (csN) begin
            fresh <= 1'b1;
        end else begin
            fresh <= 1'b0;
        end
    end

    assign edgeIdx = fresh ? 6'h00 : lk.cnt;
    assign shifted = {lk.shiftIn[22:0], si};

    always_comb begin
        next_lk         = lk;
        next_lk.shiftIn = shifted;
        next_lk.cnt     = (edgeIdx == flash_cmd_pkg::FRAME_BITS_MAX) ? edgeIdx : edgeIdx + 6'h01;
        if (fresh) begin
            next_lk.dataActive = 1'b0;
        end
        if (lk.dataActive && !fresh) begin
            next_lk.bitIdx = lk.bitIdx + 3'h1;
            if (lk.bitIdx == flash_cmd_pkg::BIT_LAST && !lk.isStatus) begin
                next_lk.addr = lk.addr + 24'h000001;
            end
        end
        if (edgeIdx == flash_cmd_pkg::OPCODE_LAST) begin
            next_lk.opcode = shifted[7:0];
            if (shifted[7:0] == flash_cmd_pkg::OP_READ_STATUS1
                || shifted[7:0] == flash_cmd_pkg::OP_READ_STATUS2) begin
                next_lk.dataActive = 1'b1;
                next_lk.isStatus   = 1'b1;
                next_lk.bitIdx     = 3'h0;
            end
        end
        if (edgeIdx == flash_cmd_pkg::ADDR_LAST) begin
            if (lk.opcode == flash_cmd_pkg::OP_READ_DATA && !st.viewBusy) begin
                next_lk.addr       = shifted;
                next_lk.dataActive = 1'b1;
                next_lk.isStatus   = 1'b0;
                next_lk.bitIdx     = 3'h0;
            end
            if (lk.opcode == flash_cmd_pkg::OP_FAST_READ) begin
                next_lk.addr = shifted;
            end
        end
        if (lk.opcode == flash_cmd_pkg::OP_FAST_READ
            && edgeIdx == flash_cmd_pkg::ADDR_LAST + st.viewDummy) begin
            next_lk.dataActive = 1'b1;
            next_lk.isStatus   = 1'b0;
            next_lk.bitIdx     = 3'h0;
        end
    end

    always_ff @(posedge sck) begin
        lk <= next_lk;
    end

    // The status view is frozen while a frame runs, so it is stable for the link side.
    always_comb begin
        if (!lk.isStatus) begin
            outByte = arrayData;
        end else if (lk.opcode == flash_cmd_pkg::OP_READ_STATUS2) begin
            outByte = st.viewSr2;
        end else begin
            outByte = st.viewSr1;
        end
    end

    always_ff @(negedge sck or posedge csN) begin
        if (csN) begin
            so   <= 1'b0;
            soEn <= 1'b0;
        end else begin
            so   <= lk.dataActive ? outByte[3'h7 - lk.bitIdx] : 1'b0;
            soEn <= lk.dataActive & ~fresh;
        end
    end

    assign arrayAddr = lk.addr;

    // System domain: chip select and the frame-start flag each cross through two flip-flops.
    // A frame counts only if sck ran while chip select was low, so a bare select pulse does nothing.
    assign frameEnd = st.csSync & ~st.csPrev & st.ran;
    assign busyNow  = st.swBusy | progEraseBusy;
    assign isPeOp   = lk.opcode == flash_cmd_pkg::OP_PAGE_PROGRAM || lk.opcode == flash_cmd_pkg::OP_QUAD_PROGRAM
                   || lk.opcode == flash_cmd_pkg::OP_ERASE_4K || lk.opcode == flash_cmd_pkg::OP_ERASE_32K
                   || lk.opcode == flash_cmd_pkg::OP_ERASE_64K || lk.opcode == flash_cmd_pkg::OP_CHIP_ERASE_A
                   || lk.opcode == flash_cmd_pkg::OP_CHIP_ERASE_B;
    assign wsValid  = (lk.opcode == flash_cmd_pkg::OP_WRITE_STATUS
                       && (lk.cnt == flash_cmd_pkg::FRAME_TWO_BYTE || lk.cnt == flash_cmd_pkg::FRAME_THREE))
                   || (lk.opcode == flash_cmd_pkg::OP_WRITE_STATUS2 && lk.cnt == flash_cmd_pkg::FRAME_TWO_BYTE);

    // New values ordered {protect zero, quad, protect one, complement}.
    always_comb begin
        if (lk.opcode == flash_cmd_pkg::OP_WRITE_STATUS2) begin
            wsNew = {st.protect_bit_zero, lk.shiftIn[flash_cmd_pkg::SR2_QUAD], lk.shiftIn[flash_cmd_pkg::SR2_PROTECT1],
                     lk.shiftIn[flash_cmd_pkg::SR2_COMPLEMENT]};
        end else if (lk.cnt == flash_cmd_pkg::FRAME_TWO_BYTE) begin
            wsNew = {lk.shiftIn[flash_cmd_pkg::SR1_PROTECT0], 3'h0};
        end else begin
            wsNew = {lk.shiftIn[8 + flash_cmd_pkg::SR1_PROTECT0], lk.shiftIn[flash_cmd_pkg::SR2_QUAD],
                     lk.shiftIn[flash_cmd_pkg::SR2_PROTECT1], st.cmp};
        end
    end

    always_comb begin
        next_st         = st;
        next_st.csMeta  = csN;
        next_st.csSync  = st.csMeta;
        next_st.csPrev  = st.csSync;
        next_st.freshMeta = fresh;
        next_st.freshSync = st.freshMeta;
        next_st.ran       = st.ran | (~st.freshSync & ~st.csSync);
        next_st.peReq   = 1'b0;
        if (progEraseDone) begin
            next_st.write_enable_latch = 1'b0;
        end
        if (st.swBusy) begin
            if (st.timer == 32'h0) begin
                next_st.swBusy = 1'b0;
                next_st.write_enable_latch    = 1'b0;
                {next_st.nvSrp0, next_st.nvQe, next_st.nvSrp1, next_st.nvCmp} = st.pend;
                {next_st.protect_bit_zero, next_st.qe, next_st.protect_bit_one, next_st.cmp}         = st.pend;
            end else begin
                next_st.timer = st.timer - 32'h1;
            end
        end
        if (frameEnd) begin
            next_st.ran        = 1'b0;
            next_st.volArmed   = 1'b0;
            next_st.resetArmed = 1'b0;
            if (!busyNow) begin
                if (lk.cnt == flash_cmd_pkg::FRAME_ONE_BYTE) begin
                    if (lk.opcode == flash_cmd_pkg::OP_WRITE_ENABLE) begin
                        next_st.write_enable_latch = 1'b1;
                    end else if (lk.opcode == flash_cmd_pkg::OP_VOLATILE_WE) begin
                        next_st.volArmed = 1'b1;
                    end else if (lk.opcode == flash_cmd_pkg::OP_WRITE_DISABLE) begin
                        next_st.write_enable_latch = 1'b0;
                    end else if (lk.opcode == flash_cmd_pkg::OP_RESET_ENABLE) begin
                        next_st.resetArmed = 1'b1;
                    end else if (lk.opcode == flash_cmd_pkg::OP_RESET && st.resetArmed) begin
                        next_st.readParam = flash_cmd_pkg::READ_PARAM_RESET;
                    end
                end
                if (wsValid && st.volArmed) begin
                    {next_st.protect_bit_zero, next_st.qe, next_st.protect_bit_one, next_st.cmp} = wsNew;
                end else if (wsValid && st.write_enable_latch) begin
                    next_st.pend   = wsNew;
                    next_st.swBusy = 1'b1;
                    next_st.timer  = 32'(STATUS_WRITE_CYCLES - 1);
                    next_st.write_enable_latch    = 1'b0;
                end
                if (isPeOp && st.write_enable_latch) begin
                    next_st.peReq    = 1'b1;
                    next_st.peOpcode = lk.opcode;
                end
                if (lk.opcode == flash_cmd_pkg::OP_SET_READ_PARAM && lk.cnt == flash_cmd_pkg::FRAME_TWO_BYTE) begin
                    next_st.readParam = lk.shiftIn[7:0];
                end
            end
        end
        // The view only follows live state while chip select is high.
        if (st.csSync) begin
            next_st.viewSr1 = 8'h00;
            next_st.viewSr1[flash_cmd_pkg::SR1_BUSY]     = busyNow;
            next_st.viewSr1[flash_cmd_pkg::SR1_WEL]      = st.write_enable_latch;
            next_st.viewSr1[flash_cmd_pkg::SR1_PROTECT0] = st.protect_bit_zero;
            next_st.viewSr2 = 8'h00;
            next_st.viewSr2[flash_cmd_pkg::SR2_PROTECT1]   = st.protect_bit_one;
            next_st.viewSr2[flash_cmd_pkg::SR2_QUAD]       = st.qe;
            next_st.viewSr2[flash_cmd_pkg::SR2_COMPLEMENT] = st.cmp;
            next_st.viewBusy = busyNow;
            if (!quadCommandMode) begin
                next_st.viewDummy = flash_cmd_pkg::DUMMY_SPI;
            end else if (st.readParam[flash_cmd_pkg::PARAM_DUMMY_HI:flash_cmd_pkg::PARAM_DUMMY_LO]
                         == flash_cmd_pkg::DUMMY_SEL_4) begin
                next_st.viewDummy = flash_cmd_pkg::DUMMY_QUAD_4;
            end else if (st.readParam[flash_cmd_pkg::PARAM_DUMMY_HI:flash_cmd_pkg::PARAM_DUMMY_LO]
                         == flash_cmd_pkg::DUMMY_SEL_6) begin
                next_st.viewDummy = flash_cmd_pkg::DUMMY_QUAD_6;
            end else begin
                next_st.viewDummy = flash_cmd_pkg::DUMMY_QUAD_8;
            end
        end
        if (srst) begin
            next_st            = '0;
            next_st.csMeta     = 1'b1;
            next_st.csSync     = 1'b1;
            next_st.csPrev     = 1'b1;
            next_st.freshSync  = 1'b1;
            next_st.write_enable_latch        = 1'b0;
            next_st.protect_bit_zero       = flash_cmd_pkg::PROTECT0_RESET;
            next_st.qe         = flash_cmd_pkg::QUAD_RESET;
            next_st.protect_bit_one       = flash_cmd_pkg::PROTECT1_RESET;
            next_st.cmp        = flash_cmd_pkg::COMPLEMENT_RESET;
            next_st.nvSrp0     = flash_cmd_pkg::PROTECT0_RESET;
            next_st.nvQe       = flash_cmd_pkg::QUAD_RESET;
            next_st.nvSrp1     = flash_cmd_pkg::PROTECT1_RESET;
            next_st.nvCmp      = flash_cmd_pkg::COMPLEMENT_RESET;
            next_st.readParam  = flash_cmd_pkg::READ_PARAM_RESET;
            next_st.viewDummy  = flash_cmd_pkg::DUMMY_SPI;
        end
    end

    always_ff @(posedge clk) begin
        st <= next_st;
    end

    assign progEraseReq         = st.peReq;
    assign progEraseOpcode      = st.peOpcode;
    assign writeEnableLatch     = st.write_enable_latch;
    assign statusWriteBusy      = st.swBusy;
    assign protectBitZero       = st.protect_bit_zero;
    assign protectBitOne        = st.protect_bit_one;
    assign quadEnableBit        = st.qe;
    assign protectComplementBit = st.cmp;
    assign readParam            = st.readParam;

    property p_wel_set;
        @(posedge clk) disable iff (srst)
        frameEnd && !busyNow && lk.cnt == flash_cmd_pkg::FRAME_ONE_BYTE
            && lk.opcode == flash_cmd_pkg::OP_WRITE_ENABLE |=> st.write_enable_latch;
    endproperty
    a_wel_set: assert property (p_wel_set) else $error("Write enable did not set the latch.");

    property p_pe_refused;
        @(posedge clk) disable iff (srst)
        frameEnd && isPeOp && !st.write_enable_latch |=> !progEraseReq;
    endproperty
    a_pe_refused: assert property (p_pe_refused) else $error("Program or erase issued without latch.");

    property p_volatile_keeps_wel;
        @(posedge clk) disable iff (srst)
        frameEnd && lk.opcode == flash_cmd_pkg::OP_VOLATILE_WE && !progEraseDone && !st.swBusy
            |=> st.write_enable_latch == $past(st.write_enable_latch);
    endproperty
    a_volatile_keeps_wel: assert property (p_volatile_keeps_wel) else $error("Volatile enable moved the latch.");

    property p_wel_clear;
        @(posedge clk) disable iff (srst)
        frameEnd && !busyNow && lk.cnt == flash_cmd_pkg::FRAME_ONE_BYTE
            && lk.opcode == flash_cmd_pkg::OP_WRITE_DISABLE |=> !st.write_enable_latch;
    endproperty
    a_wel_clear: assert property (p_wel_clear) else $error("Write disable did not clear the latch.");

    property p_busy_start;
        @(posedge clk) disable iff (srst)
        frameEnd && !busyNow && wsValid && st.write_enable_latch && !st.volArmed |=> st.swBusy && !st.write_enable_latch ##1 st.swBusy;
    endproperty
    a_busy_start: assert property (p_busy_start) else $error("Status write cycle did not start.");

    property p_busy_end;
        @(posedge clk) disable iff (srst)
        st.swBusy && st.timer == 32'h0 |=> !st.swBusy && !st.write_enable_latch && {st.protect_bit_zero, st.qe, st.protect_bit_one, st.cmp} == $past(st.pend);
    endproperty
    a_busy_end: assert property (p_busy_end) else $error("Status write cycle did not end cleanly.");

    property p_short_write;
        @(posedge clk) disable iff (srst)
        frameEnd && !busyNow && st.volArmed && lk.opcode == flash_cmd_pkg::OP_WRITE_STATUS
            && lk.cnt == flash_cmd_pkg::FRAME_TWO_BYTE |=> !st.qe && !st.protect_bit_one && !st.cmp;
    endproperty
    a_short_write: assert property (p_short_write) else $error("Short status write kept upper bits.");

    property p_bad_length;
        @(posedge clk) disable iff (srst)
        frameEnd && !st.swBusy && lk.opcode == flash_cmd_pkg::OP_WRITE_STATUS && !wsValid
            |=> !st.swBusy && $stable({st.protect_bit_zero, st.qe, st.protect_bit_one, st.cmp});
    endproperty
    a_bad_length: assert property (p_bad_length) else $error("Misframed status write was executed.");

    property p_read_while_busy;
        @(posedge sck) disable iff (csN)
        !fresh && lk.cnt == flash_cmd_pkg::ADDR_LAST && lk.opcode == flash_cmd_pkg::OP_READ_DATA && st.viewBusy
            |=> !lk.dataActive;
    endproperty
    a_read_while_busy: assert property (p_read_while_busy) else $error("Read data served while busy.");

    property p_status_start;
        @(posedge sck) disable iff (csN)
        edgeIdx == flash_cmd_pkg::OPCODE_LAST && shifted[7:0] == flash_cmd_pkg::OP_READ_STATUS1
            |=> lk.dataActive && lk.isStatus && lk.bitIdx == 3'h0 ##8 lk.bitIdx == 3'h0;
    endproperty
    a_status_start: assert property (p_status_start) else $error("Status read did not start output.");
endmodule : flash_cmd_front

// ==== testbench/flash_cmd_front_tb.sv ====
// Self-checking bench for the flash command front end.
// Assumes spi_host_model on the link and an array that returns its address xor 5Ah.
`timescale 1ns/1ns
module flash_cmd_front_tb;
    logic        clk, srst, quadCommandMode, progEraseDone, so, soEn, progEraseReq, sck, csN, si;
    logic        writeEnableLatch, statusWriteBusy, protectBitZero, protectBitOne;
    logic        quadEnableBit, protectComplementBit;
    logic [23:0] arrayAddr;
    logic [7:0]  progEraseOpcode, readParam;
    logic [63:0] rx;
    int          miscompares = 0;
    int          check_count = 0;
    int          enCount = 0;
    int          peCount = 0;
    wire  [7:0]  arrayData = arrayAddr[7:0] ^ 8'h5A;

    spi_host_model i_host (.sck(sck), .csN(csN), .si(si), .so(so));
    flash_cmd_front #(.STATUS_WRITE_CYCLES(200)) i_dut (.clk(clk), .srst(srst), .sck(sck), .csN(csN),
        .si(si), .so(so), .soEn(soEn), .arrayAddr(arrayAddr), .arrayData(arrayData),
        .quadCommandMode(quadCommandMode), .progEraseBusy(1'b0), .progEraseDone(progEraseDone),
        .progEraseReq(progEraseReq), .progEraseOpcode(progEraseOpcode), .writeEnableLatch(writeEnableLatch),
        .statusWriteBusy(statusWriteBusy), .protectBitZero(protectBitZero), .protectBitOne(protectBitOne),
        .quadEnableBit(quadEnableBit), .protectComplementBit(protectComplementBit), .readParam(readParam));

    // Counts link edges with the output driven and program or erase request pulses.
    always @(posedge sck) begin
        if (soEn === 1'b1)
            enCount++;
    end

    always @(posedge clk) begin
        if (progEraseReq === 1'b1)
            peCount++;
    end

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : wrap_up

    task automatic fr(input logic [63:0] tx, input int n);
        i_host.xfer(tx, n, rx);
        repeat (4) @(posedge clk);
        #1;
    endtask : fr

    task automatic wait_idle();
        for (int i = 0; i < 400 && statusWriteBusy !== 1'b0; i++)
            @(posedge clk);
        #1;
        if (statusWriteBusy !== 1'b0) begin
            miscompares++;
            wrap_up();
        end
    endtask : wait_idle

    task automatic t_enable_read();
        chk({writeEnableLatch, statusWriteBusy, protectBitZero, protectBitOne}, 4'h0);
        chk({quadEnableBit, protectComplementBit, readParam}, 10'h200);
        fr(64'h06, 8);
        chk(writeEnableLatch, 1'b1);
        enCount = 0;
        fr(64'h050000, 24);
        chk(rx[15:0], 16'h0202);
        chk(enCount, 16);
    endtask : t_enable_read

    task automatic t_volatile();
        fr(64'h04, 8);
        chk(writeEnableLatch, 1'b0);
        fr(64'h50, 8);
        chk(writeEnableLatch, 1'b0);
        quadCommandMode = 1'b1;
        fr(64'h0180BE, 24);
        quadCommandMode = 1'b0;
        chk({protectBitZero, quadEnableBit, statusWriteBusy}, 3'h6);
        fr(64'h350000, 24);
        chk(rx[7:0], 8'h02);
    endtask : t_volatile

    task automatic t_status_write();
        fr(64'h0100, 16);
        chk(statusWriteBusy, 1'b0);
        fr(64'h06, 8);
        fr(64'h010, 12);
        chk({writeEnableLatch, statusWriteBusy}, 2'h2);
        fr(64'h0100, 16);
        chk({writeEnableLatch, statusWriteBusy}, 2'h1);
        fr(64'h030000000000, 48);
        chk(rx, 64'h0);
        fr(64'h050000, 24);
        chk(rx[7:0], 8'h81);
        wait_idle();
        chk({protectBitZero, quadEnableBit, protectBitOne, protectComplementBit}, 4'h0);
    endtask : t_status_write

    task automatic t_reg_two();
        fr(64'h06, 8);
        fr(64'h3143, 16);
        wait_idle();
        chk({protectComplementBit, quadEnableBit, protectBitOne, writeEnableLatch}, 4'hE);
        fr(64'h350000, 24);
        chk(rx[15:0], 16'h4343);
        fr(64'h20000000, 32);
        chk(peCount, 0);
        fr(64'h06, 8);
        fr(64'h20000000, 32);
        chk(peCount, 1);
        chk(progEraseOpcode, 8'h20);
        @(posedge clk) #1 progEraseDone = 1'b1;
        @(posedge clk) #1 progEraseDone = 1'b0;
        chk(writeEnableLatch, 1'b0);
        fr(64'h50, 8);
        fr(64'h0100, 16);
        chk({quadEnableBit, protectBitOne, protectComplementBit}, 3'h0);
    endtask : t_reg_two

    task automatic t_reads();
        logic [7:0] prm [4] = '{8'h00, 8'h00, 8'h10, 8'h20};
        int         dum [4] = '{8, 4, 6, 8};
        fr(64'h030000FE0000, 48);
        chk(rx[15:0], {8'hFE ^ 8'h5A, 8'hFF ^ 8'h5A});
        for (int k = 0; k < 4; k++) begin
            quadCommandMode = (k > 0);
            if (k > 1)
                fr(64'hC000 | prm[k], 16);
            chk(readParam, prm[k]);
            fr(64'h0B000010 << (dum[k] + 8), 40 + dum[k]);
            chk(rx[7:0], 8'h10 ^ 8'h5A);
        end
        enCount = 0;
        fr(64'hFF00, 16);
        chk(rx, 64'h0);
        chk({writeEnableLatch, enCount != 0}, 2'h0);
    endtask : t_reads

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial begin
        #1000000;
        miscompares++;
        wrap_up();
    end

    initial begin
        srst = 1'b1;
        quadCommandMode = 1'b0;
        progEraseDone = 1'b0;
        repeat (3) @(posedge clk);
        #1 srst = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        t_enable_read();
        t_volatile();
        t_status_write();
        t_reg_two();
        t_reads();
        wrap_up();
    end
endmodule : flash_cmd_front_tb

// ==== testbench/spi_host_model.sv ====
// Host side of the serial link: frames commands and collects what the device returns.
// Assumes mode 0 with sck low and standing still between frames.
`timescale 1ns/1ns
module spi_host_model (
    output logic      sck,
    output logic      csN,
    output logic      si,
    input  wire logic so
);
    initial begin
        sck = 1'b0;
        csN = 1'b0;
        si  = 1'b0;
        // A first rising edge on chip select puts the link side into its idle state.
        #1 csN = 1'b1;
    end

    // Sends the low nbits of tx and returns every bit seen on so at the rising edges.
    task automatic xfer(input logic [63:0] tx, input int nbits, output logic [63:0] rx);
        rx = '0;
        #3 csN = 1'b0;
        #60;
        for (int i = nbits - 1; i >= 0; i--) begin
            si = tx[i];
            #8 sck = 1'b1;
            rx = {rx[62:0], so};
            #7 sck = 1'b0;
        end
        #8 csN = 1'b1;
        si = ~si;
        #100;
    endtask : xfer
endmodule : spi_host_model
